// file: adc_output_format_test_pattern_regs_bench.sv
`timescale 1ns/1ps
module adc_output_format_test_pattern_regs_bench;
    import aotp_pkg::*;
    localparam logic [7:0] RA [11] = '{8'h08, 8'h09, 8'h0d, 8'h14, 8'h15, 8'h16, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h30};
    localparam logic [7:0] RV [11] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] RM [11] = '{8'h07, 8'h01, 8'hff, 8'h47, 8'h30, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
    logic                  clk_sys = 1'b0;
    logic                  reset_n = 1'b0;
    logic                  reg_write = 1'b0;
    logic                  reg_read = 1'b0;
    logic [7:0]            reg_addr = 8'h00;
    logic [7:0]            reg_wdata = 8'h00;
    logic [WORD_WIDTH-1:0] sample_in = 14'h0000;
    logic [7:0]            reg_rdata;
    logic [WORD_WIDTH-1:0] data_out;
    logic [WORD_WIDTH-1:0] cap_word;
    logic [WORD_WIDTH-1:0] held;
    logic                  data_frame;
    logic                  out_clock;
    logic                  test_active;
    logic                  dcs_enable;
    logic [2:0]            chip_mode;
    logic [15:0]           pat [2];
    logic [7:0]            fmt_cfg;
    logic [7:0]            d;
    int                    cap_count;
    int                    errors = 0;
    int                    check_count = 0;
    int                    cycles = 0;
    int                    seed = 85720;

    aotp_regs i_aotp_regs (.clk_sys(clk_sys), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_in(sample_in),
        .data_out(data_out), .data_frame(data_frame), .out_clock(out_clock), .test_active(test_active),
        .dcs_enable(dcs_enable), .chip_mode(chip_mode));
    aotp_capture i_aotp_capture (.clk_sys(clk_sys), .reset_n(reset_n), .data_frame(data_frame),
        .data_out(data_out), .word(cap_word), .count(cap_count));

    always #2.5 clk_sys = ~clk_sys;

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic end_of_test();
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Each access leaves one idle cycle so a strobe is never raised in the step that lowers it.
    task automatic reg_wr(logic [7:0] a, logic [7:0] v);
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = v;
        @(posedge clk_sys);
        #1;
        reg_write = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_rd(logic [7:0] a, logic [7:0] exp);
        reg_read = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #1;
        reg_read = 1'b0;
        check("reg_rdata", exp, reg_rdata);
        @(posedge clk_sys);
        #1;
    endtask
    // The sample is held for a whole frame so the word taken at frame end is known.
    task automatic wait_frame();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (data_frame !== 1'b1 && n < 20);
        check("data_frame", 1, data_frame);
        held      = sample_in;
        sample_in = 14'($random(seed));
    endtask
    function automatic logic [13:0] expect_word(logic [3:0] code, int k, logic [13:0] s);
        logic [13:0] w;
        case (code)
            TEST_MIDSCALE:           w = 14'h2000;
            TEST_POSITIVE_FULL_SCALE: w = 14'h3fff;
            TEST_NEGATIVE_FULL_SCALE: w = 14'h0000;
            TEST_CHECKERBOARD:       w = (k % 2 == 0) ? 14'h2aaa : 14'h1555;
            TEST_LONG_PSEUDORANDOM:  w = LONG_PN_SEED[13:0];
            TEST_SHORT_PSEUDORANDOM: w = {5'h00, SHORT_PN_SEED};
            TEST_WORD_TOGGLE:        w = (k % 2 == 0) ? 14'h3fff : 14'h0000;
            TEST_USER_INPUT:         w = pat[k % 2][13:0];
            TEST_BIT_TOGGLE:         w = 14'h2aaa;
            TEST_SYNC_ONE_TIMES:     w = 14'h3f80;
            TEST_ONE_BIT_HIGH:       w = 14'h2000;
            TEST_MIXED_FREQUENCY:    w = 14'h0ccc;
            default:                 w = s;
        endcase
        if (fmt_cfg[1:0] == 2'h1) w[13] = ~w[13];
        if (fmt_cfg[2]) w = ~w;
        return w;
    endfunction

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        for (int i = 0; i < 11; i++) begin
            reg_rd(RA[i], RV[i]);
            reg_wr(RA[i], 8'hff);
            reg_rd(RA[i], RM[i]);
        end
        check("dcs_enable", 1, dcs_enable);
        check("chip_mode", 7, chip_mode);
        reg_wr(ADDR_OUTPUT_TEST_PATTERN_CONTROL, 8'h00);
        reg_wr(ADDR_CLOCK_CONDITIONING_CONTROL, 8'h00);
        reg_wr(ADDR_CHIP_OPERATING_MODE, 8'h00);
        check("dcs_enable", 0, dcs_enable);
        check("chip_mode", 0, chip_mode);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            pat[i / 2][8 * (i % 2) +: 8] = d;
            reg_wr(8'h19 + 8'(i), d);
        end
        wait_frame();
        for (int c = 0; c < 14; c++) begin
            fmt_cfg = {5'h00, c[1], 1'b0, c[0]};
            reg_wr(ADDR_OUTPUT_FORMAT_CONFIG, fmt_cfg);
            reg_wr(ADDR_OUTPUT_TEST_PATTERN_CONTROL, 8'(c) | (c == 5 ? 8'h20 : (c == 6 ? 8'h10 : 8'h00)));
            wait_frame();
            repeat (2) begin
                wait_frame();
                check("data_out", expect_word(4'(c), cap_count, held), data_out);
                check("test_active", c != 0, test_active);
            end
        end
        for (int c = 5; c < 7; c++) begin
            reg_wr(ADDR_OUTPUT_TEST_PATTERN_CONTROL, 8'(c));
            wait_frame();
            wait_frame();
            check("pn_moves", 1, data_out !== cap_word);
        end
        for (int p = 0; p < 12; p++) begin
            reg_wr(ADDR_OUTPUT_CLOCK_PHASE_SELECT, 8'(p));
            wait_frame();
            wait_frame();
            for (int j = 0; j < 6; j++) begin
                check("out_clock", ((j + 11 - (p > 10 ? 10 : p)) % 6) < 3, out_clock);
                @(posedge clk_sys);
                #1;
            end
        end
        reset_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        check("test_active", 0, test_active);
        check("dcs_enable", 1, dcs_enable);
        reg_rd(ADDR_OUTPUT_CLOCK_PHASE_SELECT, 8'h03);
        reg_rd(ADDR_OUTPUT_TEST_PATTERN_CONTROL, 8'h00);
        end_of_test();
    end
endmodule

// file: aotp_capture.sv
`timescale 1ns/1ps
module aotp_capture
    import aotp_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  data_frame,
    input  wire logic [WORD_WIDTH-1:0] data_out,
    output logic      [WORD_WIDTH-1:0] word,
    output int                         count
);
    // Capture logic keeps the last framed word and the number of frames seen.
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            count <= 0;
        end else if (data_frame) begin
            word  <= data_out;
            count <= count + 1;
        end
    end
endmodule

// file: aotp_pkg.sv
package aotp_pkg;

    // ====
    // Register offsets on the internal control port
    // ====
    localparam logic [7:0] ADDR_CHIP_OPERATING_MODE        = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_CONDITIONING_CONTROL = 8'h09;
    localparam logic [7:0] ADDR_OUTPUT_TEST_PATTERN_CONTROL = 8'h0d;
    localparam logic [7:0] ADDR_OUTPUT_FORMAT_CONFIG       = 8'h14;
    localparam logic [7:0] ADDR_OUTPUT_DRIVE_CONFIG        = 8'h15;
    localparam logic [7:0] ADDR_OUTPUT_CLOCK_PHASE_SELECT  = 8'h16;
    localparam logic [7:0] ADDR_USER_PATTERN_ONE_LOW_BYTE  = 8'h19;
    localparam logic [7:0] ADDR_USER_PATTERN_ONE_HIGH_BYTE = 8'h1a;
    localparam logic [7:0] ADDR_USER_PATTERN_TWO_LOW_BYTE  = 8'h1b;
    localparam logic [7:0] ADDR_USER_PATTERN_TWO_HIGH_BYTE = 8'h1c;

    // ====
    // Reset values
    // ====
    localparam logic [7:0] RST_CHIP_OPERATING_MODE   = 8'h00;
    localparam logic [7:0] RST_CLOCK_CONDITIONING    = 8'h01;
    localparam logic [7:0] RST_TEST_PATTERN_CONTROL  = 8'h00;
    localparam logic [7:0] RST_OUTPUT_FORMAT_CONFIG  = 8'h00;
    localparam logic [7:0] RST_OUTPUT_DRIVE_CONFIG   = 8'h00;
    localparam logic [7:0] RST_OUTPUT_CLOCK_PHASE    = 8'h03;
    localparam logic [7:0] RST_USER_PATTERN_BYTE     = 8'h00;

    // ====
    // Writable bit masks; all other bits read as zero
    // ====
    localparam logic [7:0] MASK_CHIP_OPERATING_MODE  = 8'h07;
    localparam logic [7:0] MASK_CLOCK_CONDITIONING   = 8'h01;
    localparam logic [7:0] MASK_TEST_PATTERN_CONTROL = 8'hff;
    localparam logic [7:0] MASK_OUTPUT_FORMAT_CONFIG = 8'h47;
    localparam logic [7:0] MASK_OUTPUT_DRIVE_CONFIG  = 8'h30;
    localparam logic [7:0] MASK_OUTPUT_CLOCK_PHASE   = 8'h0f;

    // ====
    // Field positions
    // ====
    localparam int FLD_DCS_ENABLE       = 0;
    localparam int FLD_TEST_MODE_LSB    = 0;
    localparam int FLD_RESET_SHORT_PN   = 4;
    localparam int FLD_RESET_LONG_PN    = 5;
    localparam int FLD_FORMAT_LSB       = 0;
    localparam int FLD_OUTPUT_INVERT    = 2;
    localparam int FLD_PHASE_LSB        = 0;

    // ====
    // Test mode, format and mode codes
    // ====
    localparam logic [3:0] TEST_OFF                  = 4'h0;
    localparam logic [3:0] TEST_MIDSCALE             = 4'h1;
    localparam logic [3:0] TEST_POSITIVE_FULL_SCALE  = 4'h2;
    localparam logic [3:0] TEST_NEGATIVE_FULL_SCALE  = 4'h3;
    localparam logic [3:0] TEST_CHECKERBOARD         = 4'h4;
    localparam logic [3:0] TEST_LONG_PSEUDORANDOM    = 4'h5;
    localparam logic [3:0] TEST_SHORT_PSEUDORANDOM   = 4'h6;
    localparam logic [3:0] TEST_WORD_TOGGLE          = 4'h7;
    localparam logic [3:0] TEST_USER_INPUT           = 4'h8;
    localparam logic [3:0] TEST_BIT_TOGGLE           = 4'h9;
    localparam logic [3:0] TEST_SYNC_ONE_TIMES       = 4'ha;
    localparam logic [3:0] TEST_ONE_BIT_HIGH         = 4'hb;
    localparam logic [3:0] TEST_MIXED_FREQUENCY      = 4'hc;

    localparam logic [1:0] FORMAT_OFFSET_BINARY      = 2'h0;
    localparam logic [1:0] FORMAT_TWOS_COMPLEMENT    = 2'h1;
    localparam logic [2:0] MODE_FULL_CHIP_OPERATION  = 3'h0;

    // ====
    // Data words, held in offset binary before formatting
    // ====
    localparam int         WORD_WIDTH                = 14;
    localparam logic [13:0] WORD_MIDSCALE            = 14'h2000;
    localparam logic [13:0] WORD_POSITIVE_FULL_SCALE = 14'h3fff;
    localparam logic [13:0] WORD_NEGATIVE_FULL_SCALE = 14'h0000;
    localparam logic [13:0] WORD_CHECKER_A           = 14'h2aaa;
    localparam logic [13:0] WORD_CHECKER_B           = 14'h1555;
    localparam logic [13:0] WORD_ALL_ONES            = 14'h3fff;
    localparam logic [13:0] WORD_ALL_ZEROS           = 14'h0000;
    localparam logic [13:0] WORD_BIT_TOGGLE          = 14'h2aaa;
    localparam logic [13:0] WORD_SYNC_ONE_TIMES      = 14'h3f80;
    localparam logic [13:0] WORD_ONE_BIT_HIGH        = 14'h2000;
    localparam logic [13:0] WORD_MIXED_FREQUENCY     = 14'h0ccc;

    // ====
    // Pseudorandom generators
    // ====
    localparam int          LONG_PN_LENGTH  = 23;
    localparam int          LONG_PN_TAP     = 18;
    localparam logic [22:0] LONG_PN_SEED    = 23'h7fffff;
    localparam int          SHORT_PN_LENGTH = 9;
    localparam int          SHORT_PN_TAP    = 5;
    localparam logic [8:0]  SHORT_PN_SEED   = 9'h1ff;

    // ====
    // Frame and output clock timing
    // ====
    localparam logic [3:0] FRAME_LAST_TICK  = 4'hb;
    localparam logic [4:0] FRAME_TICKS      = 5'h0c;
    localparam logic [2:0] CLOCK_TICKS      = 3'h6;
    localparam logic [2:0] CLOCK_HIGH_TICKS = 3'h3;
    localparam logic [3:0] PHASE_MAX_CODE   = 4'ha;

endpackage

// file: aotp_pn_gen.sv
`timescale 1ns/1ps
module aotp_pn_gen
    import aotp_pkg::*;
#(
    parameter int                LENGTH = 9,
    parameter int                TAP    = 5,
    parameter logic [LENGTH-1:0] SEED   = '1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  hold,
    input  wire logic                  advance,
    output logic      [WORD_WIDTH-1:0] word
);

    logic [LENGTH-1:0] state;
    logic [LENGTH-1:0] next_state;

    // ==========================================================
    // Fibonacci shift, one output bit per step, one word per frame
    // ==========================================================
    always_comb begin
        next_state = state;
        for (int i = 0; i < WORD_WIDTH; i++) begin
            next_state = {next_state[LENGTH-2:0], next_state[LENGTH-1] ^ next_state[TAP-1]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || hold) begin
            state <= SEED;
        end else if (advance) begin
            state <= next_state;
        end
    end

    // The short generator is narrower than a word, so it is zero-extended; the long one is cut.
    assign word = WORD_WIDTH'(state);

endmodule

// file: aotp_regs.sv
`timescale 1ns/1ps
module aotp_regs
    import aotp_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic      [7:0]            reg_rdata,
    input  wire logic [WORD_WIDTH-1:0] sample_in,
    output logic      [WORD_WIDTH-1:0] data_out,
    output logic                       data_frame,
    output logic                       out_clock,
    output logic                       test_active,
    output logic                       dcs_enable,
    output logic      [2:0]            chip_mode
);

    // ====
    // Register storage
    // ====
    logic [7:0] chip_operating_mode;
    logic [7:0] clock_conditioning_control;
    logic [7:0] output_test_pattern_control;
    logic [7:0] output_format_config;
    logic [7:0] output_drive_config;
    logic [7:0] output_clock_phase_select;
    logic [7:0] user_pattern_one_low_byte;
    logic [7:0] user_pattern_one_high_byte;
    logic [7:0] user_pattern_two_low_byte;
    logic [7:0] user_pattern_two_high_byte;

    function automatic logic hit(input logic [7:0] offset);
        return reg_write && (reg_addr == offset);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            chip_operating_mode         <= RST_CHIP_OPERATING_MODE;
            clock_conditioning_control  <= RST_CLOCK_CONDITIONING;
            output_test_pattern_control <= RST_TEST_PATTERN_CONTROL;
            output_format_config        <= RST_OUTPUT_FORMAT_CONFIG;
            output_drive_config         <= RST_OUTPUT_DRIVE_CONFIG;
            output_clock_phase_select   <= RST_OUTPUT_CLOCK_PHASE;
        end else begin
            if (hit(ADDR_CHIP_OPERATING_MODE)) begin
                chip_operating_mode <= reg_wdata & MASK_CHIP_OPERATING_MODE;
            end
            if (hit(ADDR_CLOCK_CONDITIONING_CONTROL)) begin
                clock_conditioning_control <= reg_wdata & MASK_CLOCK_CONDITIONING;
            end
            if (hit(ADDR_OUTPUT_TEST_PATTERN_CONTROL)) begin
                output_test_pattern_control <= reg_wdata & MASK_TEST_PATTERN_CONTROL;
            end
            if (hit(ADDR_OUTPUT_FORMAT_CONFIG)) begin
                output_format_config <= reg_wdata & MASK_OUTPUT_FORMAT_CONFIG;
            end
            if (hit(ADDR_OUTPUT_DRIVE_CONFIG)) begin
                output_drive_config <= reg_wdata & MASK_OUTPUT_DRIVE_CONFIG;
            end
            if (hit(ADDR_OUTPUT_CLOCK_PHASE_SELECT)) begin
                output_clock_phase_select <= reg_wdata & MASK_OUTPUT_CLOCK_PHASE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            user_pattern_one_low_byte  <= RST_USER_PATTERN_BYTE;
            user_pattern_one_high_byte <= RST_USER_PATTERN_BYTE;
            user_pattern_two_low_byte  <= RST_USER_PATTERN_BYTE;
            user_pattern_two_high_byte <= RST_USER_PATTERN_BYTE;
        end else begin
            if (hit(ADDR_USER_PATTERN_ONE_LOW_BYTE)) begin
                user_pattern_one_low_byte <= reg_wdata;
            end
            if (hit(ADDR_USER_PATTERN_ONE_HIGH_BYTE)) begin
                user_pattern_one_high_byte <= reg_wdata;
            end
            if (hit(ADDR_USER_PATTERN_TWO_LOW_BYTE)) begin
                user_pattern_two_low_byte <= reg_wdata;
            end
            if (hit(ADDR_USER_PATTERN_TWO_HIGH_BYTE)) begin
                user_pattern_two_high_byte <= reg_wdata;
            end
        end
    end

    // ====
    // Read port
    // ====
    logic [7:0] next_rdata;

    always_comb begin
        if (reg_addr == ADDR_CHIP_OPERATING_MODE) begin
            next_rdata = chip_operating_mode;
        end else if (reg_addr == ADDR_CLOCK_CONDITIONING_CONTROL) begin
            next_rdata = clock_conditioning_control;
        end else if (reg_addr == ADDR_OUTPUT_TEST_PATTERN_CONTROL) begin
            next_rdata = output_test_pattern_control;
        end else if (reg_addr == ADDR_OUTPUT_FORMAT_CONFIG) begin
            next_rdata = output_format_config;
        end else if (reg_addr == ADDR_OUTPUT_DRIVE_CONFIG) begin
            next_rdata = output_drive_config;
        end else if (reg_addr == ADDR_OUTPUT_CLOCK_PHASE_SELECT) begin
            next_rdata = output_clock_phase_select;
        end else if (reg_addr == ADDR_USER_PATTERN_ONE_LOW_BYTE) begin
            next_rdata = user_pattern_one_low_byte;
        end else if (reg_addr == ADDR_USER_PATTERN_ONE_HIGH_BYTE) begin
            next_rdata = user_pattern_one_high_byte;
        end else if (reg_addr == ADDR_USER_PATTERN_TWO_LOW_BYTE) begin
            next_rdata = user_pattern_two_low_byte;
        end else if (reg_addr == ADDR_USER_PATTERN_TWO_HIGH_BYTE) begin
            next_rdata = user_pattern_two_high_byte;
        end else begin
            next_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end
    end

    // ====
    // Control outputs
    // ====
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            dcs_enable <= RST_CLOCK_CONDITIONING[FLD_DCS_ENABLE];
            chip_mode  <= MODE_FULL_CHIP_OPERATION;
        end else begin
            dcs_enable <= clock_conditioning_control[FLD_DCS_ENABLE];
            chip_mode  <= chip_operating_mode[2:0];
        end
    end

    // ====
    // Frame timing
    // ====
    // Samples are latched on a fixed frame count; the phase field only
    // shifts the output clock, so capture timing never moves.
    logic [3:0] frame_tick;
    logic       frame_end;
    logic       word_parity;

    assign frame_end = (frame_tick == FRAME_LAST_TICK);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            frame_tick  <= 4'h0;
            word_parity <= 1'b0;
        end else begin
            frame_tick <= frame_end ? 4'h0 : frame_tick + 4'h1;
            if (frame_end) begin
                word_parity <= ~word_parity;
            end
        end
    end

    // ====
    // Pseudorandom generators
    // ====
    logic [3:0]            test_mode;
    logic [WORD_WIDTH-1:0] long_pn_word;
    logic [WORD_WIDTH-1:0] short_pn_word;

    assign test_mode = output_test_pattern_control[FLD_TEST_MODE_LSB +: 4];

    aotp_pn_gen #(
        .LENGTH (LONG_PN_LENGTH),
        .TAP    (LONG_PN_TAP),
        .SEED   (LONG_PN_SEED)
    ) long_gen (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .hold    (output_test_pattern_control[FLD_RESET_LONG_PN]),
        .advance (frame_end && test_mode == TEST_LONG_PSEUDORANDOM),
        .word    (long_pn_word)
    );

    aotp_pn_gen #(
        .LENGTH (SHORT_PN_LENGTH),
        .TAP    (SHORT_PN_TAP),
        .SEED   (SHORT_PN_SEED)
    ) short_gen (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .hold    (output_test_pattern_control[FLD_RESET_SHORT_PN]),
        .advance (frame_end && test_mode == TEST_SHORT_PSEUDORANDOM),
        .word    (short_pn_word)
    );

    // ====
    // Word selection and formatting
    // ====
    logic [WORD_WIDTH-1:0] raw_word;
    logic [WORD_WIDTH-1:0] user_word;
    logic [WORD_WIDTH-1:0] next_data;

    assign user_word = word_parity
        ? {user_pattern_two_high_byte[5:0], user_pattern_two_low_byte}
        : {user_pattern_one_high_byte[5:0], user_pattern_one_low_byte};

    always_comb begin
        case (test_mode)
            TEST_MIDSCALE:            raw_word = WORD_MIDSCALE;
            TEST_POSITIVE_FULL_SCALE: raw_word = WORD_POSITIVE_FULL_SCALE;
            TEST_NEGATIVE_FULL_SCALE: raw_word = WORD_NEGATIVE_FULL_SCALE;
            TEST_CHECKERBOARD:        raw_word = word_parity ? WORD_CHECKER_B : WORD_CHECKER_A;
            TEST_LONG_PSEUDORANDOM:   raw_word = long_pn_word;
            TEST_SHORT_PSEUDORANDOM:  raw_word = short_pn_word;
            TEST_WORD_TOGGLE:         raw_word = word_parity ? WORD_ALL_ZEROS : WORD_ALL_ONES;
            TEST_USER_INPUT:          raw_word = user_word;
            TEST_BIT_TOGGLE:          raw_word = WORD_BIT_TOGGLE;
            TEST_SYNC_ONE_TIMES:      raw_word = WORD_SYNC_ONE_TIMES;
            TEST_ONE_BIT_HIGH:        raw_word = WORD_ONE_BIT_HIGH;
            TEST_MIXED_FREQUENCY:     raw_word = WORD_MIXED_FREQUENCY;
            default:                  raw_word = sample_in;
        endcase
    end

    // Unassigned test codes fall back to live samples rather than
    // holding stale data, so a bad write is visible on the link.
    function automatic logic [WORD_WIDTH-1:0] format_word(input logic [WORD_WIDTH-1:0] w,
                                                          input logic [7:0]            cfg);
        logic [WORD_WIDTH-1:0] f;
        f = w;
        if (cfg[FLD_FORMAT_LSB +: 2] == FORMAT_TWOS_COMPLEMENT) begin
            f[WORD_WIDTH-1] = ~f[WORD_WIDTH-1];
        end
        return cfg[FLD_OUTPUT_INVERT] ? ~f : f;
    endfunction

    assign next_data = format_word(raw_word, output_format_config);

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            data_out    <= WORD_ALL_ZEROS;
            data_frame  <= 1'b0;
            test_active <= 1'b0;
        end else begin
            data_frame  <= frame_end;
            test_active <= (test_mode != TEST_OFF);
            if (frame_end) begin
                data_out <= next_data;
            end
        end
    end

    // ====
    // Output clock phase
    // ====
    logic [3:0] phase_code;
    logic [4:0] shifted_tick;
    logic [2:0] clock_tick;

    assign phase_code   = (output_clock_phase_select[3:0] > PHASE_MAX_CODE)
                        ? PHASE_MAX_CODE : output_clock_phase_select[3:0];
    assign shifted_tick = {1'b0, frame_tick} + FRAME_TICKS - {1'b0, phase_code};
    assign clock_tick   = 3'(shifted_tick % {2'b00, CLOCK_TICKS});

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            out_clock <= 1'b0;
        end else begin
            out_clock <= (clock_tick < CLOCK_HIGH_TICKS);
        end
    end

endmodule

// file: aotp_regs_monitor.sv
`timescale 1ns/1ps
module aotp_regs_monitor
    import aotp_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  reset_n,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic [7:0]            reg_rdata,
    input wire logic [WORD_WIDTH-1:0] sample_in,
    input wire logic [WORD_WIDTH-1:0] data_out,
    input wire logic                  data_frame,
    input wire logic                  out_clock,
    input wire logic                  test_active,
    input wire logic                  dcs_enable,
    input wire logic [2:0]            chip_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // Cycles since the phase field last moved
    // ==========================================================
    // A phase change legally bends one output clock period, so shape checks wait it out.
    logic [3:0] quiet;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || (reg_write && reg_addr == ADDR_OUTPUT_CLOCK_PHASE_SELECT)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end

    // ==========================================================
    // Properties
    // ==========================================================
    sequence s_gap;
        (!data_frame)[*8] ##1 (!data_frame)[*3];
    endsequence
    sequence s_mode_write;
        (reg_write && reg_addr == ADDR_OUTPUT_TEST_PATTERN_CONTROL) ##1
            !(reg_write && reg_addr == ADDR_OUTPUT_TEST_PATTERN_CONTROL);
    endsequence
    property p_frame_period;
        data_frame |=> s_gap ##1 data_frame;
    endproperty
    property p_first_frame;
        $rose(reset_n) |-> s_gap ##1 !data_frame ##1 data_frame;
    endproperty
    property p_word_holds;
        !data_frame |-> $stable(data_out);
    endproperty
    property p_clock_high;
        $fell(out_clock) && quiet > 4'h8 |-> $past(out_clock, 3) && !$past(out_clock, 4);
    endproperty
    property p_clock_low;
        $rose(out_clock) && quiet > 4'h8 |-> !$past(out_clock, 3) && $past(out_clock, 4);
    endproperty
    property p_dcs_follows;
        reg_write && reg_addr == ADDR_CLOCK_CONDITIONING_CONTROL |=> ##1 dcs_enable == $past(reg_wdata[0], 2);
    endproperty
    property p_mode_follows;
        reg_write && reg_addr == ADDR_CHIP_OPERATING_MODE |=> ##1 chip_mode == $past(reg_wdata[2:0], 2);
    endproperty
    property p_test_active;
        s_mode_write |=> test_active == ($past(reg_wdata[3:0], 2) != 4'h0);
    endproperty
    property p_unmapped_zero;
        reg_read && reg_addr == 8'h30 |=> reg_rdata == 8'h00;
    endproperty
    property p_rdata_holds;
        !reg_read |=> $stable(reg_rdata);
    endproperty

    a_frame_period:
        assert property (p_frame_period) else $error("frame spacing");
    a_first_frame:
        assert property (p_first_frame) else $error("first frame");
    a_word_holds:
        assert property (p_word_holds) else $error("word moved in frame");
    a_clock_high:
        assert property (p_clock_high) else $error("clock high time");
    a_clock_low:
        assert property (p_clock_low) else $error("clock low time");
    a_dcs_follows:
        assert property (p_dcs_follows) else $error("stabilizer enable");
    a_mode_follows:
        assert property (p_mode_follows) else $error("chip mode");
    a_test_active:
        assert property (p_test_active) else $error("test active flag");
    a_unmapped_zero:
        assert property (p_unmapped_zero) else $error("unmapped read");
    a_rdata_holds:
        assert property (p_rdata_holds) else $error("read data moved");
endmodule

bind aotp_regs aotp_regs_monitor i_aotp_regs_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sample_in(sample_in), .data_out(data_out), .data_frame(data_frame),
    .out_clock(out_clock), .test_active(test_active), .dcs_enable(dcs_enable), .chip_mode(chip_mode));
